// ===== core/ssm_top.sv
/*
 * Supply sequencer monitor: engine state machine, threshold classifier,
 * regulator enable sequencing, output flags and trim drive.
 * Assumes the converter delivers one channel sample per valid pulse, the
 * two-wire front end and store loader present decoded config writes.
 */
`timescale 1ns/1ps

module ssm_top
    import ssm_pkg::*;
(
    // clock and reset
    input  wire logic                CORE_CLK,
    input  wire logic                RESET,
    // user and host commands
    input  wire logic                SEQUENCE_TOGGLE_BUTTON,
    input  wire logic                HOST_START,
    input  wire logic                HOST_STOP,
    // configuration writes from store loader or two-wire host
    input  wire logic                CFG_WR,
    input  wire logic [CHAN_W-1:0]   CFG_CHAN,
    input  wire ssm_lim_s            CFG_DATA,
    input  wire logic [NUM_IO-1:0]   CFG_FLAG_AND,
    input  wire logic [NUM_IO-1:0]   CFG_FLAG_OR,
    // store fetch address for the loader
    output      logic [31:0]         STORE_ADDR,
    // converter samples
    input  wire ssm_smp_s            SAMPLE,
    input  wire logic [CHAN_W-1:0]   READ_CHAN,
    output      logic [MV_W-1:0]     READ_MV,
    output      logic [2:0]          READ_STATE,
    // digital pins
    input  wire logic [NUM_IO-1:0]   GP_IN,
    output      logic [NUM_IO-1:0]   GP_IN_STATE,
    output      logic [NUM_IO-1:0]   OUT_FLAGS,
    output      logic [NUM_IO-1:0]   REG_ENABLE,
    // trim drive, one code per channel
    output      logic [NUM_CHAN*TRIM_W-1:0] TRIM_CODE,
    output      logic                CLOSED_TRIM_ON,
    // status
    output      logic [1:0]          ENGINE_STATE
);

    ssm_eng_e              eng, next_eng;
    logic [CHAN_W-1:0]     seq_idx, next_seq_idx;
    logic [CNT_W-1:0]      settle, next_settle;
    logic                  btn_q;
    logic [MV_W-1:0]       volt  [NUM_CHAN];
    ssm_chst_e             cls   [NUM_CHAN];
    logic [NUM_CHAN-1:0]   is_nom;
    logic [NUM_IO-1:0]     flag_and, flag_or;
    ssm_lim_s              lim_rd;
    ssm_lim_s              lim   [NUM_CHAN];

    wire toggle   = SEQUENCE_TOGGLE_BUTTON & ~btn_q;
    wire want_on  = HOST_START | (toggle & (eng == ENG_STOPPED));
    wire want_off = HOST_STOP  | (toggle & (eng == ENG_STARTED));
    wire start_ok = want_on  && (eng == ENG_STOPPED);
    wire stop_ok  = want_off && (eng == ENG_STARTED);
    wire monitor  = (eng != ENG_STOPPED);
    wire settled  = (settle == '0);
    wire last_ch  = (seq_idx == CHAN_W'(NUM_CHAN - 1));
    wire cur_nom  = is_nom[seq_idx];

    // mirror of the config table, also written into the registered memory
    ssm_cfg_mem u_cfg (
        .clk     (CORE_CLK),
        .wr_en   (CFG_WR),
        .wr_addr (CFG_CHAN),
        .wr_data (CFG_DATA),
        .rd_addr (READ_CHAN),
        .rd_data (lim_rd)
    );

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            flag_and <= '0;
            flag_or  <= '0;
        end else if (CFG_WR) begin
            flag_and <= CFG_FLAG_AND;
            flag_or  <= CFG_FLAG_OR;
        end
    end

    // engine sequencing
    always_comb begin
        next_eng     = eng;
        next_seq_idx = seq_idx;
        next_settle  = settled ? settle : settle - 1'b1;
        case (eng)
            ENG_STOPPED: begin
                if (start_ok) begin
                    next_eng     = ENG_STARTING;
                    next_seq_idx = '0;
                    next_settle  = CNT_W'(SETTLE_CYC);
                end
            end
            ENG_STARTING: begin
                if (settled) begin
                    if (!cur_nom) begin
                        next_seq_idx = '0;
                        next_settle  = CNT_W'(SETTLE_CYC);
                    end else if (last_ch) begin
                        next_eng = ENG_STARTED;
                    end else begin
                        next_seq_idx = seq_idx + 1'b1;
                        next_settle  = CNT_W'(SETTLE_CYC);
                    end
                end
            end
            ENG_STARTED: begin
                if (stop_ok) begin
                    next_eng     = ENG_STOPPING;
                    next_seq_idx = CHAN_W'(NUM_CHAN - 1);
                    next_settle  = CNT_W'(SETTLE_CYC);
                end
            end
            ENG_STOPPING: begin
                if (settled) begin
                    if (seq_idx == '0) begin
                        next_eng = ENG_STOPPED;
                    end else begin
                        next_seq_idx = seq_idx - 1'b1;
                        next_settle  = CNT_W'(SETTLE_CYC);
                    end
                end
            end
            default: next_eng = ENG_STOPPED;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            eng     <= ENG_STOPPED;
            seq_idx <= '0;
            settle  <= '0;
            btn_q   <= 1'b0;
        end else begin
            eng     <= next_eng;
            seq_idx <= next_seq_idx;
            settle  <= next_settle;
            btn_q   <= SEQUENCE_TOGGLE_BUTTON;
        end
    end

    // per-channel voltage, classification with hysteresis and trim
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_ch
            logic [TRIM_W-1:0] trim;
            logic [MV_W-1:0]   v, h;
            logic              hit;
            logic              uv2, uv1, ov1, ov2, en_now;
            ssm_chst_e         c_raw;
            assign v      = volt[g];
            assign h      = lim[g].hysteresis;
            assign hit    = SAMPLE.valid && (SAMPLE.chan == CHAN_W'(g));
            assign en_now = REG_ENABLE[g];
            // each threshold moves by hysteresis away from the current class
            assign uv2 = (cls[g] <= CH_SECOND_UNDER_VOLTAGE)
                       ? (v < lim[g].second_under_voltage + h)
                       : (v + h < lim[g].second_under_voltage);
            assign uv1 = (cls[g] <= CH_FIRST_UNDER_VOLTAGE)
                       ? (v < lim[g].first_under_voltage + h)
                       : (v + h < lim[g].first_under_voltage);
            assign ov1 = (cls[g] >= CH_FIRST_OVER_VOLTAGE)
                       ? (v + h > lim[g].first_over_voltage)
                       : (v > lim[g].first_over_voltage + h);
            assign ov2 = (cls[g] == CH_SECOND_OVER_VOLTAGE)
                       ? (v + h > lim[g].second_over_voltage)
                       : (v > lim[g].second_over_voltage + h);
            assign c_raw = !en_now ? CH_OFF :
                           ov2 ? CH_SECOND_OVER_VOLTAGE :
                           ov1 ? CH_FIRST_OVER_VOLTAGE :
                           uv2 ? CH_SECOND_UNDER_VOLTAGE :
                           uv1 ? CH_FIRST_UNDER_VOLTAGE :
                           CH_NOMINAL;
            assign is_nom[g] = (cls[g] == CH_NOMINAL);
            assign TRIM_CODE[g*TRIM_W +: TRIM_W] = trim;

            always_ff @(posedge CORE_CLK or posedge RESET) begin
                if (RESET) begin
                    volt[g] <= '0;
                    cls[g]  <= CH_OFF;
                    trim    <= TRIM_MID;
                    lim[g]  <= '0;
                end else begin
                    if (CFG_WR && CFG_CHAN == CHAN_W'(g)) begin
                        lim[g] <= CFG_DATA;
                    end
                    if (hit) begin
                        volt[g] <= SAMPLE.mv;
                    end
                    cls[g] <= monitor ? c_raw : CH_OFF;
                    // closed loop: one step per sample toward nominal
                    if (CLOSED_TRIM_ON && lim[g].closed_trim && hit) begin
                        if (SAMPLE.mv < lim[g].nominal && trim != '1) begin
                            trim <= trim + 1'b1;
                        end else if (SAMPLE.mv > lim[g].nominal
                                     && trim != '0) begin
                            trim <= trim - 1'b1;
                        end
                    end else if (eng == ENG_STOPPED) begin
                        trim <= TRIM_MID;
                    end
                end
            end
        end
    endgenerate

    // enables: channels up to seq_idx on while starting, down while stopping
    logic [NUM_IO-1:0] next_en;
    always_comb begin
        next_en = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            case (eng)
                ENG_STARTING: next_en[i] = (CHAN_W'(i) <= seq_idx);
                ENG_STARTED:  next_en[i] = 1'b1;
                ENG_STOPPING: next_en[i] = (CHAN_W'(i) < seq_idx)
                                           || (CHAN_W'(i) == seq_idx
                                               && !settled);
                default:      next_en[i] = 1'b0;
            endcase
        end
    end

    // flags: nominal status masked and combined with inputs
    logic [NUM_IO-1:0] nom_vec;
    assign nom_vec = NUM_IO'(is_nom);

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            REG_ENABLE     <= '0;
            OUT_FLAGS      <= '0;
            GP_IN_STATE    <= '0;
            CLOSED_TRIM_ON <= 1'b0;
            ENGINE_STATE   <= 2'h0;
            READ_MV        <= '0;
            READ_STATE     <= 3'h0;
            STORE_ADDR     <= RST_ZERO32;
        end else begin
            REG_ENABLE  <= next_en;
            GP_IN_STATE <= GP_IN;
            OUT_FLAGS   <= monitor
                         ? ((nom_vec | (GP_IN & flag_or)) & ~(GP_IN & flag_and))
                         : '0;
            CLOSED_TRIM_ON <= (next_eng == ENG_STARTED);
            ENGINE_STATE   <= eng;
            READ_MV        <= volt[(READ_CHAN < CHAN_W'(NUM_CHAN))
                                   ? READ_CHAN : '0];
            READ_STATE     <= cls[(READ_CHAN < CHAN_W'(NUM_CHAN))
                                   ? READ_CHAN : '0];
            STORE_ADDR     <= CFG_BASE_OFS
                            + {24'h000000, CFG_WORDS} * 32'(READ_CHAN);
        end
    end

    // open-loop trim is the reset midpoint code held while starting
    sequence s_stop_req;
        stop_ok;
    endsequence

    property p_start_only_stopped;
        @(posedge CORE_CLK) disable iff (RESET)
        (eng == ENG_STOPPED && !start_ok) |=> (eng == ENG_STOPPED);
    endproperty
    a_start_only_stopped: assert property (p_start_only_stopped)
        else $error("engine left stopped without start");

    property p_stop_trim_off;
        @(posedge CORE_CLK) disable iff (RESET)
        s_stop_req |=> ##1 !CLOSED_TRIM_ON;
    endproperty
    a_stop_trim_off: assert property (p_stop_trim_off)
        else $error("closed trim still on while stopping");

    property p_started_all_on;
        @(posedge CORE_CLK) disable iff (RESET)
        (eng == ENG_STARTED) |=> (REG_ENABLE[NUM_CHAN-1:0] == '1);
    endproperty
    a_started_all_on: assert property (p_started_all_on)
        else $error("started with a regulator disabled");

    property p_stopped_idle;
        @(posedge CORE_CLK) disable iff (RESET)
        (eng == ENG_STOPPED) ##1 (eng == ENG_STOPPED)
            |=> (OUT_FLAGS == '0 && !CLOSED_TRIM_ON);
    endproperty
    a_stopped_idle: assert property (p_stopped_idle)
        else $error("flags or trim active while stopped");

    property p_state_code;
        @(posedge CORE_CLK) disable iff (RESET)
        1'b1 |=> (ENGINE_STATE == $past(eng));
    endproperty
    a_state_code: assert property (p_state_code)
        else $error("engine state code stale");

    property p_not_nom_restart;
        @(posedge CORE_CLK) disable iff (RESET)
        (eng == ENG_STARTING && settled && !cur_nom)
            |=> (seq_idx == '0 && eng == ENG_STARTING);
    endproperty
    a_not_nom_restart: assert property (p_not_nom_restart)
        else $error("power-on did not restart on failed channel");

    property p_gpin;
        @(posedge CORE_CLK) disable iff (RESET)
        1'b1 |=> (GP_IN_STATE == $past(GP_IN));
    endproperty
    a_gpin: assert property (p_gpin)
        else $error("input state not sampled");

    property p_toggle_on;
        @(posedge CORE_CLK) disable iff (RESET)
        (eng == ENG_STOPPED && toggle) |=> (eng == ENG_STARTING);
    endproperty
    a_toggle_on: assert property (p_toggle_on)
        else $error("toggle did not start power-on");

endmodule // ssm_top

// ===== core/ssm_pkg.sv
/*
 * Shared constants and types for the supply sequencer monitor.
 * Assumes a single 100 MHz core clock and synchronous pin inputs.
 */
package ssm_pkg;

    localparam int NUM_CHAN = 22;
    localparam int NUM_IO   = 32;
    localparam int MV_W     = 16;
    localparam int CHAN_W   = 5;
    localparam int TRIM_W   = 8;

    // configuration store base offset in the nonvolatile store
    localparam logic [31:0] CFG_BASE_OFS   = 32'h0003f000;
    // words per channel record: limits, hysteresis, nominal, trim flags
    localparam logic [7:0]  CFG_WORDS      = 8'h08;
    localparam logic [31:0] RST_ZERO32     = 32'h00000000;
    localparam logic [7:0]  TRIM_MID       = 8'h80;

    // settle time after a regulator enable, before checking nominal;
    // kept short so a whole 22-channel walk stays cheap to exercise
    localparam int SETTLE_US     = 5;
    localparam int CLK_MHZ       = 100;
    localparam int SETTLE_CYC    = SETTLE_US * CLK_MHZ;
    localparam int CNT_W         = 16;

    typedef enum logic [1:0] {
        ENG_STOPPED,
        ENG_STARTING,
        ENG_STARTED,
        ENG_STOPPING
    } ssm_eng_e;

    // declaration order matters: the classifier compares by rank
    typedef enum logic [2:0] {
        CH_OFF,
        CH_SECOND_UNDER_VOLTAGE,
        CH_FIRST_UNDER_VOLTAGE,
        CH_NOMINAL,
        CH_FIRST_OVER_VOLTAGE,
        CH_SECOND_OVER_VOLTAGE
    } ssm_chst_e;

    // per-channel limits as loaded from the store
    typedef struct packed {
        logic [MV_W-1:0] second_under_voltage;
        logic [MV_W-1:0] first_under_voltage;
        logic [MV_W-1:0] first_over_voltage;
        logic [MV_W-1:0] second_over_voltage;
        logic [MV_W-1:0] hysteresis;
        logic [MV_W-1:0] nominal;
        logic            open_trim;
        logic            closed_trim;
    } ssm_lim_s;

    localparam int LIM_W = $bits(ssm_lim_s);

    // one voltage sample from the converter
    typedef struct packed {
        logic              valid;
        logic [CHAN_W-1:0] chan;
        logic [MV_W-1:0]   mv;
    } ssm_smp_s;

endpackage : ssm_pkg

// ===== core/ssm_cfg_mem.sv
/*
 * Configuration memory: one limits record per channel, registered read.
 * Assumes writes arrive from the store loader or the two-wire front end.
 */
`timescale 1ns/1ps
module ssm_cfg_mem
    import ssm_pkg::*;
(
    // clock
    input  wire logic              clk,
    // write port
    input  wire logic              wr_en,
    input  wire logic [CHAN_W-1:0] wr_addr,
    input  wire ssm_lim_s          wr_data,
    // read port
    input  wire logic [CHAN_W-1:0] rd_addr,
    output      ssm_lim_s          rd_data
);

    ssm_lim_s mem [NUM_CHAN];

    always_ff @(posedge clk) begin
        if (wr_en && (wr_addr < CHAN_W'(NUM_CHAN))) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[(rd_addr < CHAN_W'(NUM_CHAN)) ? rd_addr : '0];
    end

endmodule // ssm_cfg_mem

// ===== testbench/ssm_reg_model.sv
/*
 * Behavioural regulator bank seen by the sequencer: reports one channel
 * voltage every four cycles, round robin over all channels.
 * Assumes trim codes centre on the midpoint and move the output 1 mV/step.
 */
`timescale 1ns/1ps
module ssm_reg_model
    import ssm_pkg::*;
#(
    parameter int NOM_MV = 1000
)
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // regulator controls from the sequencer
    input  wire logic [NUM_IO-1:0]          reg_enable,
    input  wire logic [NUM_CHAN*TRIM_W-1:0] trim_code,
    // fault injection: channel never reaches its level
    input  wire logic [NUM_CHAN-1:0]        stuck_low,
    // converter samples back to the sequencer
    output      ssm_smp_s                   sample
);
    logic [CHAN_W-1:0] chan;
    logic [1:0]        gap;
    logic [TRIM_W-1:0] trim;
    logic [MV_W-1:0]   level;

    assign trim  = trim_code[int'(chan)*TRIM_W +: TRIM_W];
    // trim moves the output, so closed trim has something to correct
    assign level = MV_W'(NOM_MV) + MV_W'(trim) - MV_W'(TRIM_MID);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan   <= '0;
            gap    <= '0;
            sample <= '0;
        end else begin
            gap          <= gap + 2'h1;
            sample.valid <= (gap == 2'h3);
            sample.chan  <= chan;
            // a switched-off regulator reads 0 mV
            sample.mv    <= (reg_enable[chan] && !stuck_low[chan]) ? level
                            : '0;
            if (gap == 2'h3) begin
                chan <= (chan == CHAN_W'(NUM_CHAN-1)) ? '0 : chan + 5'h01;
            end
        end
    end
endmodule // ssm_reg_model

// ===== testbench/tb_supply_sequencer_monitor.sv
/*
 * Self-checking bench for the supply sequencer monitor.
 * Assumes a settle time short enough for whole power-on/off walks.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_supply_sequencer_monitor;
    import ssm_pkg::*;
    localparam int NOM = 1000;
    localparam int STEP = SETTLE_CYC + 1;
    logic CORE_CLK, RESET, SEQUENCE_TOGGLE_BUTTON, HOST_START, HOST_STOP;
    logic                       CFG_WR;
    logic [CHAN_W-1:0]          CFG_CHAN, READ_CHAN;
    ssm_lim_s                   CFG_DATA;
    logic [NUM_IO-1:0]          and_m, or_m, GP_IN, GP_IN_STATE;
    logic [NUM_IO-1:0]          OUT_FLAGS, REG_ENABLE;
    logic [31:0]                STORE_ADDR;
    ssm_smp_s                   SAMPLE;
    logic [MV_W-1:0]            READ_MV;
    logic [2:0]                 READ_STATE;
    logic [NUM_CHAN*TRIM_W-1:0] TRIM_CODE;
    logic                       CLOSED_TRIM_ON;
    logic [1:0]                 ENGINE_STATE;
    logic [NUM_CHAN-1:0]        stuck;
    int                         err_total, checked, k, n;
    logic [31:0]                exp_en, nom;

    ssm_top DUT (.CORE_CLK(CORE_CLK), .RESET(RESET),
        .SEQUENCE_TOGGLE_BUTTON(SEQUENCE_TOGGLE_BUTTON),
        .HOST_START(HOST_START), .HOST_STOP(HOST_STOP), .CFG_WR(CFG_WR),
        .CFG_CHAN(CFG_CHAN), .CFG_DATA(CFG_DATA), .CFG_FLAG_AND(and_m),
        .CFG_FLAG_OR(or_m), .STORE_ADDR(STORE_ADDR), .SAMPLE(SAMPLE),
        .READ_CHAN(READ_CHAN), .READ_MV(READ_MV), .READ_STATE(READ_STATE),
        .GP_IN(GP_IN), .GP_IN_STATE(GP_IN_STATE), .OUT_FLAGS(OUT_FLAGS),
        .REG_ENABLE(REG_ENABLE), .TRIM_CODE(TRIM_CODE),
        .CLOSED_TRIM_ON(CLOSED_TRIM_ON), .ENGINE_STATE(ENGINE_STATE));

    ssm_reg_model #(.NOM_MV(NOM)) regs (.clk(CORE_CLK), .rst(RESET),
        .reg_enable(REG_ENABLE), .trim_code(TRIM_CODE), .stuck_low(stuck),
        .sample(SAMPLE));

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    task automatic tick(input int c);
        repeat (c) @(posedge CORE_CLK);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(3);
    endtask

    // reads one channel through the readback port and checks it
    task automatic rd(input int ch, input logic [2:0] st, input int mv);
        READ_CHAN = CHAN_W'(ch);
        tick(2);
        `CHK(READ_STATE, st)
        `CHK(READ_MV, MV_W'(mv))
    endtask

    // same limits on every channel, one nominal moved up by 5 mV
    task automatic cfg_all(input int odd);
        for (int c = 0; c < NUM_CHAN; c++) begin
            CFG_WR = 1'b1;
            CFG_CHAN = CHAN_W'(c);
            CFG_DATA.nominal = MV_W'((c == odd) ? NOM + 5 : NOM);
            tick(1);
            `CHK(TRIM_CODE[c*TRIM_W +: TRIM_W], TRIM_MID)
        end
        CFG_WR = 1'b0;
    endtask

    // flag rule: nominal bits or-ed and masked by the general inputs
    function automatic logic [31:0] exp_flags(input logic [31:0] nv);
        return (nv | (GP_IN & or_m)) & ~(GP_IN & and_m);
    endfunction

    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // whole run is about 25000 cycles; the 60000-cycle limit means a hang
    initial begin
        #600000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(99625));
        {RESET, SEQUENCE_TOGGLE_BUTTON, HOST_START, HOST_STOP} = 4'h8;
        {CFG_WR, CFG_CHAN, READ_CHAN, GP_IN, stuck} = '0;
        CFG_DATA = '{NOM-200, NOM-100, NOM+100, NOM+200, 10, NOM, 1'b1, 1'b1};
        and_m = $urandom;
        or_m  = $urandom;
        err_total = 0;
        checked = 0;
        tick(12);
        RESET = 1'b0;
        tick(1);
        `CHK(ENGINE_STATE, ENG_STOPPED)
        `CHK(REG_ENABLE, 32'h00000000)
        `CHK(CLOSED_TRIM_ON, 1'b0)
        cfg_all(3);
        for (k = 0; k < 6; k++) begin
            n = $urandom_range(0, NUM_CHAN-1);
            READ_CHAN = CHAN_W'(n);
            GP_IN = $urandom;
            tick(2);
            `CHK(STORE_ADDR, 32'h0003f000 + 32'(8*n))
            `CHK(GP_IN_STATE, GP_IN)
            `CHK(OUT_FLAGS, 32'h00000000)
        end
        pulse(HOST_STOP);
        `CHK(ENGINE_STATE, ENG_STOPPED)
        stuck = 22'h000004;
        SEQUENCE_TOGGLE_BUTTON = 1'b1;
        tick(4);
        SEQUENCE_TOGGLE_BUTTON = 1'b0;
        `CHK(ENGINE_STATE, ENG_STARTING)
        `CHK(REG_ENABLE, 32'h00000001)
        pulse(HOST_START);
        pulse(HOST_STOP);
        tick(SETTLE_CYC / 2);
        // channel 2 never settles, so the walk must go back to channel 0
        for (k = 0; k < 4; k++) begin
            n = (k == 3) ? 1 : k + 1;
            exp_en = (32'h1 << n) - 32'h1;
            nom = exp_en & ~32'(stuck);
            `CHK(REG_ENABLE, exp_en)
            `CHK(ENGINE_STATE, ENG_STARTING)
            `CHK(CLOSED_TRIM_ON, 1'b0)
            for (n = 0; n < NUM_CHAN; n++) begin
                `CHK(TRIM_CODE[n*TRIM_W +: TRIM_W], TRIM_MID)
            end
            `CHK(OUT_FLAGS, exp_flags(nom))
            rd(0, CH_NOMINAL, NOM);
            rd(5, CH_OFF, 0);
            if (k == 2) begin
                rd(2, CH_SECOND_UNDER_VOLTAGE, 0);
            end
            tick(SETTLE_CYC - 3);
        end
        // second reset in mid-sequence
        RESET = 1'b1;
        tick(2);
        RESET = 1'b0;
        tick(1);
        `CHK(ENGINE_STATE, ENG_STOPPED)
        `CHK(REG_ENABLE, 32'h00000000)
        stuck = '0;
        // reset clears the limits, so they are loaded again before a start
        cfg_all(3);
        pulse(HOST_START);
        `CHK(ENGINE_STATE, ENG_STARTING)
        SEQUENCE_TOGGLE_BUTTON = 1'b1;
        tick(4);
        SEQUENCE_TOGGLE_BUTTON = 1'b0;
        `CHK(ENGINE_STATE, ENG_STARTING)
        tick(NUM_CHAN * STEP);
        `CHK(ENGINE_STATE, ENG_STARTED)
        `CHK(CLOSED_TRIM_ON, 1'b1)
        `CHK(REG_ENABLE, 32'h003fffff)
        // channel 3 wants 5 mV more: one trim step per sample of it
        tick(8 * NUM_CHAN * 4);
        `CHK(TRIM_CODE[3*TRIM_W +: TRIM_W], TRIM_MID + 8'h05)
        `CHK(TRIM_CODE[0*TRIM_W +: TRIM_W], TRIM_MID)
        `CHK(ENGINE_STATE, ENG_STARTED)
        nom = 32'h003fffff;
        `CHK(OUT_FLAGS, exp_flags(nom))
        rd(3, CH_NOMINAL, NOM + 5);
        SEQUENCE_TOGGLE_BUTTON = 1'b1;
        tick(4);
        SEQUENCE_TOGGLE_BUTTON = 1'b0;
        `CHK(ENGINE_STATE, ENG_STOPPING)
        `CHK(CLOSED_TRIM_ON, 1'b0)
        pulse(HOST_START);
        `CHK(ENGINE_STATE, ENG_STOPPING)
        // two channels already walked down, the third still settling
        tick(2 * STEP);
        nom = 32'h000fffff;
        `CHK(REG_ENABLE, nom)
        `CHK(OUT_FLAGS, exp_flags(nom))
        `CHK(TRIM_CODE[3*TRIM_W +: TRIM_W], TRIM_MID + 8'h05)
        tick(20 * STEP);
        `CHK(ENGINE_STATE, ENG_STOPPED)
        `CHK(REG_ENABLE, 32'h00000000)
        `CHK(OUT_FLAGS, 32'h00000000)
        `CHK(CLOSED_TRIM_ON, 1'b0)
        `CHK(TRIM_CODE[3*TRIM_W +: TRIM_W], TRIM_MID)
        tick(NUM_CHAN * 4);
        rd(0, CH_OFF, 0);
        tally_and_finish();
    end
endmodule // tb_supply_sequencer_monitor
